// >>> pkg/io_pass_pkg.sv
// shared constants and types for the i/o line passing output block
package io_pass_pkg;
  localparam int CLK_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int TENTH_NS = 100000000;
  localparam int PWM_PERIOD_NS = 64000;
  localparam int PWM_STEPS = 1023;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam int TENTH_CYC = TENTH_NS / CLK_NS;
  localparam int PWM_STEP_CYC = (PWM_PERIOD_NS / CLK_NS) / PWM_STEPS;
  localparam int CNT_W = 32;
  localparam int LINES = 8;
  localparam int LVL_W = 10;

  localparam logic [4:0] ID_SAMPLE_INTERVAL = 5'h00;
  localparam logic [4:0] ID_BOUND_ADDR = 5'h01;
  localparam logic [4:0] ID_LINE_TIMEOUT0 = 5'h02;
  localparam logic [4:0] ID_LINE_TIMEOUT7 = 5'h09;
  localparam logic [4:0] ID_PWM_A_CFG = 5'h0a;
  localparam logic [4:0] ID_PWM_B_CFG = 5'h0b;
  localparam logic [4:0] ID_PWM_A_LEVEL = 5'h0c;
  localparam logic [4:0] ID_PWM_B_LEVEL = 5'h0d;
  localparam logic [4:0] ID_PWM_TIMEOUT = 5'h0e;
  localparam logic [4:0] ID_SIGNAL_STRENGTH_INDICATION_HOLD = 5'h0f;

  localparam logic [15:0] RST_SAMPLE_INTERVAL = 16'h0000;
  localparam logic [63:0] RST_BOUND_ADDR = 64'h000f_ffff_ffff_ffff;
  localparam logic [63:0] ADDR_NONE = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] ADDR_ANY = 64'h0000_0000_0000_ffff;
  localparam logic [7:0] RST_LINE_TIMEOUT = 8'hff;
  localparam logic [7:0] RST_PWM_A_CFG = 8'h01;
  localparam logic [7:0] RST_PWM_B_CFG = 8'h00;
  localparam logic [7:0] RST_PWM_TIMEOUT = 8'hff;
  localparam logic [7:0] RST_SIGNAL_STRENGTH_INDICATION_HOLD = 8'h28;
  localparam logic [7:0] SIGNAL_STRENGTH_INDICATION_HOLD_FOREVER = 8'hff;
  localparam logic [LVL_W-1:0] LVL_ZERO = 10'h000;
  localparam logic [LVL_W-1:0] LVL_FULL = 10'h3ff;

  typedef enum logic [7:0]
  {
    PIN_DISABLED = 8'h00,
    PIN_SIGNAL_STRENGTH_INDICATION = 8'h01,
    PIN_PWM = 8'h02
  } pin_cfg_t;

  typedef struct packed
  {
    logic valid;
    logic write;
    logic apply;
    logic [4:0] id;
    logic [63:0] data;
  } cmd_t;

  typedef struct packed
  {
    logic valid;
    logic srcLong;
    logic [63:0] src;
    logic [7:0] dioMask;
    logic [7:0] dioLevel;
    logic chanZeroValid;
    logic [LVL_W-1:0] chanZero;
    logic chanOneValid;
    logic [LVL_W-1:0] chanOne;
    logic [LVL_W-1:0] signal_strength_indication;
  } pkt_t;

  typedef struct packed
  {
    logic [7:0] cnt;
    logic run;
    logic expire;
  } tenth_state_t;
endpackage

// >>> hdl/tenth_timer.sv
// one timeout counter in 100 ms ticks, used per line and for the pwm outputs
`timescale 1ns/10ps
module tenth_timer
  import io_pass_pkg::*;
(
  input wire logic sysClk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [7:0] setting,
  output logic running,
  output logic expire
);
  tenth_state_t st_r;
  tenth_state_t st_nxt;

  // ====================================================================
  // counting
  // first tick may come early: the tick grid is shared, so resolution is one tick
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.expire = 1'b0;
    if (stop)
    begin
      st_nxt.run = 1'b0;
    end
    else if (start)
    begin
      st_nxt.cnt = setting;
      // R8 zero never runs
      st_nxt.run = (setting != 8'h00);
    end
    else if (tick && st_r.run)
    begin
      if (st_r.cnt == 8'h01)
      begin
        st_nxt.run = 1'b0;
        st_nxt.expire = 1'b1;
      end
      st_nxt.cnt = st_r.cnt - 8'h01;
    end
  end

  always_ff @(posedge sysClk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign running = st_r.run;
  assign expire = st_r.expire;

  // ====================================================================
  // checks
  a_zero_setting: assert property (@(posedge sysClk) disable iff (!rst_n)
    (start && !stop && setting == 8'h00) |=> !running) else $error("zero setting started timer");
endmodule

// >>> hdl/io_line_passing_outputs.sv
// output side of i/o line passing: sample timer, address filter, line timeouts, pwm
`timescale 1ns/10ps
// Contract
// R1 - nonzero sample interval gives one sample pulse per interval milliseconds.
// R2 - host should keep transmissions no faster than one per 20 ms.
// R3 - bound address all ones blocks every packet from driving outputs; the strength duty still loads from any valid packet.
// R4 - bound address 0xffff lets every packet drive outputs.
// R5 - bound address holds short or long address; only matching sender drives; the strength duty still follows any sender.
// R6 - non-default line level starts timeout times 100 ms, then reverts.
// R7 - every matching packet restarts running line timers.
// R8 - line timeout zero holds the received level forever.
// R9 - pwm a config: 0 off, 1 strength, 2 pwm; resets to 1.
// R10 - pwm b config accepts only 0 and 2; resets to 0.
// R11 - matching packet loads channel zero sample into pwm a level.
// R12 - matching packet loads channel one sample into pwm b level.
// R13 - pwm period 64 us in 1023 steps, high time follows level. The code steps every 15 cycles, so its period is 61.38 us.
// R14 - pwm levels are 10 bits, reset to zero.
// R15 - host sets pin to pwm and applies before writing a level.
// R16 - packet-set nonzero pwm starts shared timeout; expiry zeroes both pwm.
// R17 - strength mode shows last packet strength for hold time, else zero.
// R18 - sample interval zero disables periodic sampling.
module io_line_passing_outputs
  import io_pass_pkg::*;
#(
  parameter int MsCyc = MS_CYC,
  parameter int TenthCyc = TENTH_CYC,
  parameter int PwmStepCyc = PWM_STEP_CYC
)
(
  input wire logic sysClk,
  input wire logic rst_n,
  input wire cmd_t cmd,
  input wire pkt_t pkt,
  input wire logic [7:0] lineDefault,
  output logic respValid,
  output logic [63:0] respData,
  output logic sampleTick,
  output logic [7:0] lineOut,
  output logic pwmAOut,
  output logic pwmBOut
);
  if (MsCyc < 1 || TenthCyc < 1 || PwmStepCyc < 1)
  begin : g_check
    $error("tick counts must be at least one cycle");
  end

  typedef struct packed
  {
    logic [15:0] sampleInterval;
    logic [63:0] boundAddr;
    logic [LINES-1:0][7:0] lineTimeout;
    logic [7:0] pwmACfgPend;
    logic [7:0] pwmBCfgPend;
    logic [7:0] pwmACfg;
    logic [7:0] pwmBCfg;
    logic [LVL_W-1:0] pwmALevel;
    logic [LVL_W-1:0] pwmBLevel;
    logic pwmFromPkt;
    logic [7:0] pwmTimeout;
    logic [7:0] rssiHold;
    logic [LVL_W-1:0] rssiDuty;
    logic [7:0] lineDriven;
    logic [7:0] lineHeld;
    logic [7:0] lineOut;
    logic [CNT_W-1:0] msPre;
    logic [15:0] msCount;
    logic sampleTick;
    logic [CNT_W-1:0] tenthPre;
    logic tenthTick;
    logic [CNT_W-1:0] stepPre;
    logic [LVL_W-1:0] pwmCnt;
    logic pwmAOut;
    logic pwmBOut;
    logic respValid;
    logic [63:0] respData;
  } main_state_t;

  main_state_t st_r;
  main_state_t st_nxt;
  logic pktOk;
  logic [7:0] lineStart;
  logic [7:0] lineStop;
  logic [7:0] lineRun;
  logic [7:0] lineExp;
  logic pwmTmoStart;
  logic pwmTmoRun;
  logic pwmTmoExp;
  logic rssiStart;
  logic rssiExp;
  logic [LVL_W-1:0] dutyA;
  logic [LVL_W-1:0] dutyB;

  // ====================================================================
  // source address filter
  always_comb
  begin
    pktOk = 1'b0;
    if (!pkt.valid || st_r.boundAddr == ADDR_NONE)
      // R3 all ones blocks
      pktOk = 1'b0;
    else if (st_r.boundAddr == ADDR_ANY)
      // R4 wildcard address
      pktOk = 1'b1;
    else if (pkt.srcLong)
      // R5 long address match
      pktOk = (pkt.src == st_r.boundAddr);
    else
      pktOk = (pkt.src[15:0] == st_r.boundAddr[15:0]) && (st_r.boundAddr[63:16] == 48'h0);
  end

  // ====================================================================
  // timers
  for (genvar j = 0; j < LINES; j++)
  begin : g_line
    tenth_timer u_line
    (
      .sysClk(sysClk),
      .rst_n(rst_n),
      .tick(st_r.tenthTick),
      .start(lineStart[j]),
      .stop(lineStop[j]),
      .setting(st_r.lineTimeout[j]),
      .running(lineRun[j]),
      .expire(lineExp[j])
    );
  end

  tenth_timer u_pwm_timeout
  (
    .sysClk(sysClk),
    .rst_n(rst_n),
    .tick(st_r.tenthTick),
    .start(pwmTmoStart),
    .stop(1'b0),
    .setting(st_r.pwmTimeout),
    .running(pwmTmoRun),
    .expire(pwmTmoExp)
  );

  tenth_timer u_signal_strength_indication_hold
  (
    .sysClk(sysClk),
    .rst_n(rst_n),
    .tick(st_r.tenthTick),
    .start(rssiStart),
    .stop(1'b0),
    .setting(st_r.rssiHold),
    .running(),
    .expire(rssiExp)
  );

  // ====================================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sampleTick = 1'b0;
    st_nxt.tenthTick = 1'b0;
    st_nxt.respValid = 1'b0;
    lineStart = 8'h00;
    lineStop = 8'h00;
    pwmTmoStart = 1'b0;
    rssiStart = 1'b0;

    // host commands; settings a packet also touches are overridden below
    if (cmd.valid && cmd.write)
    begin
      case (cmd.id)
        ID_SAMPLE_INTERVAL:
        begin
          st_nxt.sampleInterval = cmd.data[15:0];
          st_nxt.msPre = '0;
          st_nxt.msCount = 16'h0000;
        end
        // R5 stores either address width
        ID_BOUND_ADDR: st_nxt.boundAddr = cmd.data;
        // R9 out-of-range codes are refused
        ID_PWM_A_CFG:
          if (cmd.data <= 64'(PIN_PWM))
            st_nxt.pwmACfgPend = cmd.data[7:0];
        // R10 only disabled or pwm accepted
        ID_PWM_B_CFG:
          if (cmd.data == 64'(PIN_DISABLED) || cmd.data == 64'(PIN_PWM))
            st_nxt.pwmBCfgPend = cmd.data[7:0];
        // R14 ten bit level
        ID_PWM_A_LEVEL: st_nxt.pwmALevel = cmd.data[LVL_W-1:0];
        ID_PWM_B_LEVEL: st_nxt.pwmBLevel = cmd.data[LVL_W-1:0];
        ID_PWM_TIMEOUT: st_nxt.pwmTimeout = cmd.data[7:0];
        ID_SIGNAL_STRENGTH_INDICATION_HOLD: st_nxt.rssiHold = cmd.data[7:0];
        default:
          if (cmd.id >= ID_LINE_TIMEOUT0 && cmd.id <= ID_LINE_TIMEOUT7)
            st_nxt.lineTimeout[3'(cmd.id - ID_LINE_TIMEOUT0)] = cmd.data[7:0];
      endcase
    end
    else if (cmd.valid)
    begin
      st_nxt.respValid = 1'b1;
      case (cmd.id)
        ID_SAMPLE_INTERVAL: st_nxt.respData = 64'(st_r.sampleInterval);
        ID_BOUND_ADDR: st_nxt.respData = st_r.boundAddr;
        ID_PWM_A_CFG: st_nxt.respData = 64'(st_r.pwmACfgPend);
        ID_PWM_B_CFG: st_nxt.respData = 64'(st_r.pwmBCfgPend);
        ID_PWM_A_LEVEL: st_nxt.respData = 64'(st_r.pwmALevel);
        ID_PWM_B_LEVEL: st_nxt.respData = 64'(st_r.pwmBLevel);
        ID_PWM_TIMEOUT: st_nxt.respData = 64'(st_r.pwmTimeout);
        ID_SIGNAL_STRENGTH_INDICATION_HOLD: st_nxt.respData = 64'(st_r.rssiHold);
        default:
          if (cmd.id >= ID_LINE_TIMEOUT0 && cmd.id <= ID_LINE_TIMEOUT7)
            st_nxt.respData = 64'(st_r.lineTimeout[3'(cmd.id - ID_LINE_TIMEOUT0)]);
          else
            st_nxt.respData = 64'h0;
      endcase
    end
    // pin modes change only on apply, so a level write cannot glitch a half-set pin
    if (cmd.valid && cmd.apply)
    begin
      st_nxt.pwmACfg = st_r.pwmACfgPend;
      st_nxt.pwmBCfg = st_r.pwmBCfgPend;
    end

    // R1 millisecond sample timer; a new interval restarts it, else the count could overshoot
    if (st_r.sampleInterval != 16'h0000 &&
      !(cmd.valid && cmd.write && cmd.id == ID_SAMPLE_INTERVAL))
    begin
      if (st_r.msPre == CNT_W'(MsCyc - 1))
      begin
        st_nxt.msPre = '0;
        if (st_r.msCount + 16'h0001 == st_r.sampleInterval)
        begin
          st_nxt.msCount = 16'h0000;
          st_nxt.sampleTick = 1'b1;
        end
        else
          st_nxt.msCount = st_r.msCount + 16'h0001;
      end
      else
        st_nxt.msPre = st_r.msPre + CNT_W'(1);
    end
    else
    begin
      // R18 zero interval stops timer
      st_nxt.msPre = '0;
      st_nxt.msCount = 16'h0000;
    end

    // shared 100 ms tick
    if (st_r.tenthPre == CNT_W'(TenthCyc - 1))
    begin
      st_nxt.tenthPre = '0;
      st_nxt.tenthTick = 1'b1;
    end
    else
      st_nxt.tenthPre = st_r.tenthPre + CNT_W'(1);

    // R6 expiry returns line to default
    st_nxt.lineDriven = st_r.lineDriven & ~lineExp;
    for (int j = 0; j < LINES; j++)
    begin
      if (pktOk && pkt.dioMask[j])
      begin
        st_nxt.lineDriven[j] = 1'b1;
        st_nxt.lineHeld[j] = pkt.dioLevel[j];
      end
      if (pktOk)
      begin
        // R6 R7 start or restart while non-default
        lineStart[j] = st_nxt.lineDriven[j] && (st_nxt.lineHeld[j] != lineDefault[j]);
        lineStop[j] = !lineStart[j];
      end
      st_nxt.lineOut[j] = st_nxt.lineDriven[j] ? st_nxt.lineHeld[j] : lineDefault[j];
    end

    // R16 shared pwm timeout forces zero
    if (pwmTmoExp && st_r.pwmFromPkt)
    begin
      st_nxt.pwmALevel = LVL_ZERO;
      st_nxt.pwmBLevel = LVL_ZERO;
      st_nxt.pwmFromPkt = 1'b0;
    end
    if (pktOk)
    begin
      // R11 channel zero to pwm a
      if (pkt.chanZeroValid && st_r.pwmACfg == PIN_PWM)
      begin
        st_nxt.pwmALevel = pkt.chanZero;
        st_nxt.pwmFromPkt = 1'b1;
      end
      // R12 channel one to pwm b
      if (pkt.chanOneValid && st_r.pwmBCfg == PIN_PWM)
      begin
        st_nxt.pwmBLevel = pkt.chanOne;
        st_nxt.pwmFromPkt = 1'b1;
      end
      // R16 nonzero start, any matching packet restarts
      pwmTmoStart = st_nxt.pwmFromPkt &&
        (st_nxt.pwmALevel != LVL_ZERO || st_nxt.pwmBLevel != LVL_ZERO);
    end

    // R17 strength follows any received packet while the hold setting is nonzero
    if (rssiExp && st_r.rssiHold != SIGNAL_STRENGTH_INDICATION_HOLD_FOREVER)
      st_nxt.rssiDuty = LVL_ZERO;
    if (pkt.valid && st_r.rssiHold != 8'h00)
    begin
      st_nxt.rssiDuty = pkt.signal_strength_indication;
      rssiStart = (st_r.rssiHold != SIGNAL_STRENGTH_INDICATION_HOLD_FOREVER);
    end

    // R13 1023-step period counter
    if (st_r.stepPre == CNT_W'(PwmStepCyc - 1))
    begin
      st_nxt.stepPre = '0;
      st_nxt.pwmCnt = (st_r.pwmCnt == LVL_W'(PWM_STEPS - 1)) ? LVL_ZERO : st_r.pwmCnt + LVL_W'(1);
    end
    else
      st_nxt.stepPre = st_r.stepPre + CNT_W'(1);
    st_nxt.pwmAOut = (st_r.pwmCnt < dutyA);
    st_nxt.pwmBOut = (st_r.pwmCnt < dutyB);
  end

  // R9 R10 mode decode for pwm a and pwm b
  always_comb
  begin
    case (st_r.pwmACfg)
      PIN_PWM: dutyA = st_r.pwmALevel;
      PIN_SIGNAL_STRENGTH_INDICATION: dutyA = st_r.rssiDuty;
      default: dutyA = LVL_ZERO;
    endcase
    dutyB = (st_r.pwmBCfg == PIN_PWM) ? st_r.pwmBLevel : LVL_ZERO;
  end

  always_ff @(posedge sysClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.sampleInterval <= RST_SAMPLE_INTERVAL;
      st_r.boundAddr <= RST_BOUND_ADDR;
      st_r.lineTimeout <= {LINES{RST_LINE_TIMEOUT}};
      st_r.pwmACfgPend <= RST_PWM_A_CFG;
      st_r.pwmACfg <= RST_PWM_A_CFG;
      st_r.pwmBCfgPend <= RST_PWM_B_CFG;
      st_r.pwmBCfg <= RST_PWM_B_CFG;
      st_r.pwmTimeout <= RST_PWM_TIMEOUT;
      st_r.rssiHold <= RST_SIGNAL_STRENGTH_INDICATION_HOLD;
    end
    else
      st_r <= st_nxt;
  end

  assign respValid = st_r.respValid;
  assign respData = st_r.respData;
  assign sampleTick = st_r.sampleTick;
  assign lineOut = st_r.lineOut;
  assign pwmAOut = st_r.pwmAOut;
  assign pwmBOut = st_r.pwmBOut;

  // ====================================================================
  // checks
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (!rst_n);

  a_sample_off: assert property (st_r.sampleInterval == 16'h0000 |=> !sampleTick) // R18
    else $error("sample pulse with zero interval");
  a_sample_gap: assert property (sampleTick |=> !sampleTick) // R1
    else $error("sample pulses back to back");
  a_filter_none: assert property (st_r.boundAddr == ADDR_NONE |-> !pktOk) // R3
    else $error("blocked address accepted packet");
  a_filter_any: assert property ((st_r.boundAddr == ADDR_ANY && pkt.valid) |-> pktOk) // R4
    else $error("wildcard address refused packet");
  a_filter_long: assert property ((pktOk && pkt.srcLong && st_r.boundAddr != ADDR_ANY) // R5
    |-> pkt.src == st_r.boundAddr)
    else $error("long address mismatch accepted");
  a_line_restart: assert property ((pktOk && lineRun[0] && st_nxt.lineDriven[0] // R7
    && st_nxt.lineHeld[0] != lineDefault[0]) |-> lineStart[0])
    else $error("running line timer not restarted");
  a_line_revert: assert property ((lineExp[0] && !pktOk) |=> !st_r.lineDriven[0]) // R6
    else $error("line did not revert on expiry");
  a_line_hold: assert property (st_r.lineTimeout[1] == 8'h00 && !lineRun[1] // R8
    |=> !lineExp[1])
    else $error("disabled line timer expired");
  a_pin_b_cfg: assert property (st_r.pwmBCfgPend != PIN_SIGNAL_STRENGTH_INDICATION) // R10
    else $error("pwm b took strength mode");
  a_pin_a_cfg: assert property (st_r.pwmACfgPend <= PIN_PWM) // R9
    else $error("pwm a config out of range");
  a_chan_zero_load: assert property ((pktOk && pkt.chanZeroValid // R11
    && st_r.pwmACfg == PIN_PWM) |=> st_r.pwmALevel == $past(pkt.chanZero))
    else $error("channel zero sample not loaded");
  a_chan_one_load: assert property ((pktOk && pkt.chanOneValid // R12
    && st_r.pwmBCfg == PIN_PWM) |=> st_r.pwmBLevel == $past(pkt.chanOne))
    else $error("channel one sample not loaded");
  a_pwm_full: assert property (dutyA == LVL_FULL |=> pwmAOut) // R13
    else $error("full level not high");
  a_pwm_zero: assert property (dutyB == LVL_ZERO |=> !pwmBOut) // R13
    else $error("zero level not low");
  a_pwm_tmo_force: assert property ((pwmTmoExp && st_r.pwmFromPkt // R16
    && !pktOk && !cmd.valid)
    |=> st_r.pwmALevel == LVL_ZERO && st_r.pwmBLevel == LVL_ZERO)
    else $error("pwm timeout did not zero levels");
  a_signal_strength_indication_drop: assert property ((rssiExp && !pkt.valid // R17
    && st_r.rssiHold != SIGNAL_STRENGTH_INDICATION_HOLD_FOREVER) |=> st_r.rssiDuty == LVL_ZERO)
    else $error("strength duty held past hold time");

  c_sample: cover property (sampleTick);
  c_line_expire: cover property (lineExp != 8'h00);
  c_pwm_load: cover property (pktOk && pkt.chanZeroValid && st_r.pwmACfg == PIN_PWM);
  c_pwm_tmo_expire: cover property (pwmTmoExp && pwmTmoRun == 1'b0);
endmodule

// >>> tb/io_pass_partner.sv
// far-side model: host issuing settings and a remote node sending i/o packets
`timescale 1ns/10ps
module io_pass_partner
  import io_pass_pkg::*;
(
  input wire logic sysClk,
  output cmd_t cmd,
  output pkt_t pkt
);
  cmd_t cq;
  pkt_t pq;

  initial
  begin
    cmd = '0;
    pkt = '0;
  end

  // ==========================================================
  // host commands
  // one-cycle request; idle fields show the inverse so stale data is never mistaken
  task automatic hostCmd(input logic w, input logic ap, input logic [4:0] id,
                         input logic [63:0] d);
    cq = '0;
    cq.valid = 1'b1;
    cq.write = w;
    cq.apply = ap;
    cq.id = id;
    cq.data = d;
    @(posedge sysClk);
    cmd <= cq;
    @(posedge sysClk);
    cq = ~cq;
    cq.valid = 1'b0;
    cmd <= cq;
  endtask

  // ==========================================================
  // remote packets
  // spacing is chosen by the caller; a recommendation only
  task automatic sendPkt(input pkt_t p);
    @(posedge sysClk);
    pkt <= p;
    @(posedge sysClk);
    pq = ~p;
    pq.valid = 1'b0;
    pkt <= pq;
  endtask
endmodule

// >>> tb/io_line_passing_outputs_bench.sv
// self-checking bench for the i/o line passing output block
`timescale 1ns/10ps
module io_line_passing_outputs_bench;
  import io_pass_pkg::*;
  localparam int MsC = 4;
  localparam int TenC = 20;
  localparam int StepC = 1;
  logic sysClk, rst_n, respValid, sampleTick, pwmAOut, pwmBOut;
  logic [7:0] lineDefault, lineOut;
  logic [63:0] respData, addr, sh, got;
  logic [9:0] lvl;
  cmd_t cmd;
  pkt_t pkt;
  int errors, compares, g, h, iv;

  io_line_passing_outputs #(.MsCyc(MsC), .TenthCyc(TenC), .PwmStepCyc(StepC))
    u_io_line_passing_outputs (.sysClk(sysClk), .rst_n(rst_n), .cmd(cmd), .pkt(pkt),
    .lineDefault(lineDefault), .respValid(respValid), .respData(respData),
    .sampleTick(sampleTick), .lineOut(lineOut), .pwmAOut(pwmAOut), .pwmBOut(pwmBOut));
  io_pass_partner u_io_pass_partner (.sysClk(sysClk), .cmd(cmd), .pkt(pkt));

  initial
  begin
    sysClk = 1'b0;
    forever #2 sysClk = ~sysClk;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [4:0] id, input logic [63:0] v);
    u_io_pass_partner.hostCmd(1'b1, 1'b0, id, v);
  endtask

  task automatic rd(input logic [4:0] id, output logic [63:0] v);
    u_io_pass_partner.hostCmd(1'b0, 1'b0, id, 64'h0);
    #1;
    check("respValid", {63'h0, respValid}, 64'h1);
    v = respData;
  endtask

  task automatic pk(input logic lng, input logic [63:0] src, input logic [7:0] msk,
                    input logic [7:0] lev, input logic [9:0] a0, input logic [9:0] a1);
    pkt_t p;
    p = '0;
    p.valid = 1'b1;
    p.srcLong = lng;
    p.src = src;
    p.dioMask = msk;
    p.dioLevel = lev;
    p.chanZeroValid = 1'b1;
    p.chanZero = a0;
    p.chanOneValid = 1'b1;
    p.chanOne = a1;
    p.signal_strength_indication = 10'h155;
    u_io_pass_partner.sendPkt(p);
    repeat (2) @(posedge sysClk);
    #1;
  endtask

  // cycles until the next sample pulse; a lost pulse ends the run
  task automatic waitTick(output int n);
    n = 0;
    do
    begin
      @(posedge sysClk);
      #1;
      n++;
    end while (sampleTick !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      errors++;
      wrap_up();
    end
  endtask

  // high cycles over one full pwm period
  task automatic meas(input logic b, output int n);
    n = 0;
    repeat (1023 * StepC)
    begin
      @(posedge sysClk);
      #1;
      n += (b ? pwmBOut : pwmAOut) === 1'b1;
    end
  endtask

  function automatic logic [63:0] rstVal(input int i);
    case (i)
      0: return 64'(RST_SAMPLE_INTERVAL);
      1: return RST_BOUND_ADDR;
      10: return 64'(RST_PWM_A_CFG);
      11: return 64'(RST_PWM_B_CFG);
      14: return 64'(RST_PWM_TIMEOUT);
      15: return 64'(RST_SIGNAL_STRENGTH_INDICATION_HOLD);
      default: return (i >= 2 && i <= 9) ? 64'(RST_LINE_TIMEOUT) : 64'h0;
    endcase
  endfunction

  initial
  begin
    repeat (100000) @(posedge sysClk);
    errors++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'hb95eee97));
    rst_n = 1'b0;
    lineDefault = 8'($urandom) & 8'hfc;
    repeat (3) @(posedge sysClk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sysClk);
    #1;
    check("lineOut", 64'(lineOut), 64'(lineDefault));
    for (int i = 0; i < 17; i++)
    begin
      rd(5'(i), got);
      check("reset value", got, rstVal(i));
    end
    // sample pulses spaced by the interval in milliseconds
    for (int k = 0; k < 3; k++)
    begin
      iv = $urandom_range(5, 1);
      wr(ID_SAMPLE_INTERVAL, 64'(iv));
      waitTick(g);
      waitTick(g);
      check("sample gap", 64'(g), 64'(iv * MsC));
    end
    wr(ID_SAMPLE_INTERVAL, 64'h0);
    h = 0;
    repeat (80)
    begin
      @(posedge sysClk);
      #1;
      h += sampleTick === 1'b1;
    end
    check("idle ticks", 64'(h), 64'h0);
    // address filter with line 0 held forever; strength mode ignores the filter
    wr(ID_LINE_TIMEOUT0, 64'h0);
    wr(ID_BOUND_ADDR, ADDR_NONE);
    wr(ID_SIGNAL_STRENGTH_INDICATION_HOLD, 64'(SIGNAL_STRENGTH_INDICATION_HOLD_FOREVER));
    pk(1'b0, 64'h1234, 8'h01, 8'h01, 10'h0, 10'h0);
    check("blocked", 64'(lineOut[0]), 64'h0);
    meas(1'b0, h);
    check("strength held", 64'(h), 64'h155 * StepC);
    wr(ID_SIGNAL_STRENGTH_INDICATION_HOLD, 64'h1);
    pk(1'b0, 64'h1234, 8'h00, 8'h00, 10'h0, 10'h0);
    repeat (30) @(posedge sysClk);
    meas(1'b0, h);
    check("strength drop", 64'(h), 64'h0);
    wr(ID_BOUND_ADDR, ADDR_ANY);
    pk(1'b0, 64'($urandom_range(16'hfffe, 0)), 8'h01, 8'h01, 10'h0, 10'h0);
    check("any sender", 64'(lineOut[0]), 64'h1);
    addr = {16'h00a5, 32'($urandom), 16'($urandom)};
    wr(ID_BOUND_ADDR, addr);
    rd(ID_BOUND_ADDR, got);
    check("long addr", got, addr);
    pk(1'b1, addr ^ 64'h1, 8'h01, 8'h00, 10'h0, 10'h0);
    check("wrong sender", 64'(lineOut[0]), 64'h1);
    pk(1'b1, addr, 8'h01, 8'h00, 10'h0, 10'h0);
    check("long match", 64'(lineOut[0]), 64'h0);
    sh = 64'(16'($urandom_range(16'hfffe, 0)));
    wr(ID_BOUND_ADDR, sh);
    pk(1'b0, sh, 8'h01, 8'h01, 10'h0, 10'h0);
    check("short match", 64'(lineOut[0]), 64'h1);
    // line 1 timeout of two ticks, kept alive by traffic
    wr(ID_LINE_TIMEOUT0 + 5'h1, 64'h2);
    pk(1'b0, sh, 8'h02, 8'h02, 10'h0, 10'h0);
    check("line set", 64'(lineOut[1]), 64'h1);
    repeat (6)
    begin
      repeat (15) @(posedge sysClk);
      pk(1'b0, sh, 8'h00, 8'h00, 10'h0, 10'h0);
    end
    check("line kept", 64'(lineOut[1]), 64'h1);
    repeat (10) @(posedge sysClk);
    check("line early", 64'(lineOut[1]), 64'h1);
    repeat (35) @(posedge sysClk);
    check("line expired", 64'(lineOut[1]), 64'h0);
    check("line 0 held", 64'(lineOut[0]), 64'h1);
    check("other lines", 64'(lineOut[7:2]), 64'(lineDefault[7:2]));
    // pwm a: configure, apply, then load from channel zero
    wr(ID_BOUND_ADDR, ADDR_ANY);
    wr(ID_PWM_A_CFG, 64'(PIN_PWM));
    u_io_pass_partner.hostCmd(1'b0, 1'b1, 5'h0, 64'h0);
    for (int k = 0; k < 4; k++)
    begin
      lvl = (k == 0) ? 10'h1ff : (k == 1) ? LVL_FULL : (k == 2) ? LVL_ZERO : 10'($urandom);
      pk(1'b0, 64'h7, 8'h00, 8'h00, lvl, 10'h0);
      meas(1'b0, h);
      check("pwm a high", 64'(h), 64'(lvl) * StepC);
    end
    rd(ID_PWM_A_LEVEL, got);
    check("pwm a level", got, 64'(lvl));
    wr(ID_PWM_A_CFG, 64'h3);
    wr(ID_PWM_B_CFG, 64'h1);
    u_io_pass_partner.hostCmd(1'b0, 1'b1, 5'h0, 64'h0);
    rd(ID_PWM_A_CFG, got);
    check("cfg a refused", got, 64'(PIN_PWM));
    rd(ID_PWM_B_CFG, got);
    check("cfg b refused", got, 64'(PIN_DISABLED));
    // pwm b from channel one, then from a host level
    wr(ID_PWM_B_CFG, 64'(PIN_PWM));
    u_io_pass_partner.hostCmd(1'b0, 1'b1, 5'h0, 64'h0);
    lvl = 10'($urandom);
    pk(1'b0, 64'h7, 8'h00, 8'h00, 10'h0, lvl);
    meas(1'b1, h);
    check("pwm b high", 64'(h), 64'(lvl) * StepC);
    wr(ID_PWM_B_LEVEL, 64'(LVL_FULL));
    repeat (3) @(posedge sysClk);
    meas(1'b1, h);
    check("pwm b host", 64'(h), 64'(LVL_FULL) * StepC);
    // shared pwm timeout of one tick zeroes a packet-set duty
    wr(ID_PWM_TIMEOUT, 64'h1);
    pk(1'b0, 64'h7, 8'h00, 8'h00, 10'h200, 10'h0);
    repeat (30) @(posedge sysClk);
    meas(1'b0, h);
    check("pwm a timeout", 64'(h), 64'h0);
    wrap_up();
  end
endmodule
